// ---- src/acl_pkg.sv ----
// constants shared by the clipper / limiter chain
// assumes a 125 MHz bus clock and 24-bit signed audio words
package acl_pkg;
  // sample and gain formats
  localparam int SW = 24;
  localparam int GW = 20;
  localparam int GF = 14;
  localparam logic [SW-1:0] FULL = 24'h400000;
  localparam logic [SW-1:0] KNEE_HC = 24'h300000;
  typedef logic signed [7:0] acl_db_t;

  // processing rate
  localparam int CLK_HZ = 125_000_000;
  localparam int FS_HZ = 256_000;
  localparam int TICK_CYC = CLK_HZ / FS_HZ;
  localparam int TW = 9;

  // bus side
  localparam int AW = 8;
  localparam logic [2:0] W_SIZE = 3'h2;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_BASS = 8'h04;
  localparam logic [AW-1:0] A_DRV = 8'h08;
  localparam logic [AW-1:0] A_PWR = 8'h0C;
  localparam logic [AW-1:0] A_STAT = 8'h10;

  // control bits and byte field positions
  localparam int C_FIVE = 0;
  localparam int C_PWR = 1;
  localparam int C_CEN = 2;
  localparam int C_HCOS = 3;
  localparam int F0 = 0;
  localparam int F1 = 8;
  localparam int F2 = 16;

  // setting limits, all in half-dB steps except shape (tenths)
  localparam acl_db_t BASS_MIN = 8'hF4;
  localparam acl_db_t DB_ZERO = 8'h00;
  localparam acl_db_t SHAPE_MAX = 8'h64;
  localparam acl_db_t FD_MIN = 8'hFA;
  localparam acl_db_t FD_MAX = 8'h0A;
  localparam acl_db_t OS_MIN = 8'hFC;
  localparam acl_db_t OS_MAX = 8'h04;
  localparam acl_db_t CD_MAX = 8'h06;
  localparam acl_db_t PO_MIN = 8'hEE;
  localparam acl_db_t PT_MIN = 8'hF4;
  localparam acl_db_t PT_MAX = 8'h0C;

  // reset values
  localparam logic [3:0] CTRL_RST = 4'hD;
  localparam acl_db_t BASS_RST = 8'hFA;
  localparam acl_db_t SHAPE_RST = 8'h4C;

  // knee span: shape*31/256 approximates shape*12/100 half-dB steps
  localparam int KNEE_K = 31;
  localparam int KNEE_SH = 8;
  localparam int LP_SH = 2;
  localparam logic [7:0] LIN_OFS = 8'h24;
  localparam logic [7:0] LIN_STEP = 8'h0C;
endpackage

// ---- src/acl_chain.sv ----
// clipper / limiter back end with its AHB-Lite register slave and input FIFO
// assumes upstream and downstream stream logic on hclk, one word bus master
// Functional notes
// - bass clip threshold 0 to -6 dB
// - bass clip after band sum or bass
// - speech selects its own bass threshold
// - knee shape 0..10, soft starts 6 dB
// - final drive scales clipper and compensator
// - final clipper runs at 256 kHz
// - composite drive off or 0-3 dB
// - composite hard or half-cosine mode
// - composite overshoot fixed and bandlimited
// - compensator drive -2 to +2 dB
// - compensator runs at 256 kHz
// - power offset only while controller active
// - positive threshold dB cuts loss dB
// - combined offset never above 0 dB
// - power offset 0 to -9 dB
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module acl_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0]   cnt_q;
  logic [PW:0]   cnt_d;
  logic          push;
  logic          pop;

  // handshakes on both sides
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  assign cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);

  // storage has no reset, only pointers, count and ready do
  always_ff @(posedge hclk) begin
    if (ce && push) begin
      mem[wp_q] <= in_data;
    end
  end

  // ready is registered so the top output stays a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
    end else if (ce) begin
      wp_q <= wp_q + PW'(push);
      rp_q <= rp_q + PW'(pop);
      cnt_q <= cnt_d;
      in_ready <= (cnt_d < (PW+1)'(D));
    end
  end
endmodule

module acl_chain
  import acl_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output var  logic                  hreadyout,
  output var  logic                  hresp,
  output var  logic [31:0]           hrdata,
  input  wire logic [acl_pkg::SW-1:0] band1_in,
  input  wire logic [acl_pkg::SW-1:0] band2_in,
  input  wire logic [acl_pkg::SW-1:0] rest_in,
  input  wire logic                  speech_in,
  input  wire logic                  in_valid,
  output var  logic                  in_ready,
  output var  logic [acl_pkg::SW-1:0] audio_out,
  output var  logic [acl_pkg::SW-1:0] comp_out,
  output var  logic                  out_valid,
  input  wire logic                  out_ready
);
  import acl_pkg::*;
  localparam int FW = 3*SW + 1;

  // saturate a half-dB setting into its legal span
  function automatic acl_db_t clampdb(input acl_db_t v, input acl_db_t lo,
                                      input acl_db_t hi);
    clampdb = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // half-dB steps to linear gain, 2^(h/12), 14 fraction bits
  function automatic logic [GW-1:0] db2lin(input acl_db_t h);
    logic [7:0]  u;
    logic [7:0]  e;
    logic [15:0] m;
    u = 8'(h) + LIN_OFS;
    e = u / LIN_STEP;
    case (u % LIN_STEP)
      8'h00: m = 16'h4000;
      8'h01: m = 16'h43CE;
      8'h02: m = 16'h47D6;
      8'h03: m = 16'h4C1C;
      8'h04: m = 16'h50A3;
      8'h05: m = 16'h556E;
      8'h06: m = 16'h5A82;
      8'h07: m = 16'h5FE4;
      8'h08: m = 16'h6598;
      8'h09: m = 16'h6BA2;
      8'h0A: m = 16'h7209;
      default: m = 16'h78D1;
    endcase
    db2lin = (GW'(m) << e) >> 3;
  endfunction

  // sample times gain, kept wide so nothing wraps
  function automatic logic signed [31:0] scale(input logic signed [31:0] x,
                                              input logic [GW-1:0] g);
    logic signed [52:0] p;
    p = x * $signed({1'b0, g});
    scale = p[GF+31:GF];
  endfunction

  // symmetric saturation at +/- thr
  function automatic logic signed [SW-1:0] clip(input logic signed [31:0] x,
                                               input logic [SW-1:0] thr);
    logic signed [31:0] t;
    t = $signed({8'h00, thr});
    if (x > t) begin
      clip = t[SW-1:0];
    end else if (x < -t) begin
      clip = SW'(-t);
    end else begin
      clip = x[SW-1:0];
    end
  endfunction

  // above ks the slope halves, then hard stop at thr
  function automatic logic signed [SW-1:0] knee(input logic signed [31:0] x,
                                               input logic [SW-1:0] ks,
                                               input logic [SW-1:0] thr);
    logic signed [31:0] a;
    logic signed [31:0] k;
    k = $signed({8'h00, ks});
    a = (x < 0) ? -x : x;
    if (a > k) begin
      a = k + ((a - k) >>> 1);
    end
    knee = clip((x < 0) ? -a : a, thr);
  endfunction

  // magnitude test used by the status flags
  function automatic logic over(input logic signed [31:0] x,
                                input logic [SW-1:0] thr);
    over = (x > $signed({8'h00, thr})) || (x < -$signed({8'h00, thr}));
  endfunction

  // registers
  logic [3:0]  ctrl_q;
  acl_db_t     bass_q;
  acl_db_t     speech_q;
  acl_db_t     shape_q;
  acl_db_t     fdrv_q;
  acl_db_t     osdrv_q;
  acl_db_t     cdrv_q;
  acl_db_t     poff_q;
  acl_db_t     pthr_q;
  logic [2:0]  flags_q;
  logic [15:0] scnt_q;
  logic        wr_q;
  logic [AW-1:0] wa_q;
  logic [TW-1:0] tick_q;
  logic signed [SW-1:0] prev_q;
  logic signed [31:0]   lp_q;

  // fifo between upstream and the rate-paced chain
  logic          f_valid;
  logic          f_ready;
  logic [FW-1:0] f_data;
  logic          tick;

  acl_fifo #(.W(FW), .D(8)) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({speech_in, band1_in, band2_in, rest_in}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // one sample per 256 kHz slot, stalled while the output is unread
  // 256 kHz pacing
  assign tick = (tick_q == TW'(TICK_CYC - 1));
  assign f_ready = tick & (~out_valid | out_ready);

  // unpack the fifo word
  logic                 sp;
  logic signed [SW-1:0] b1;
  logic signed [SW-1:0] b2;
  logic signed [SW-1:0] rs;
  assign {sp, b1, b2, rs} = f_data;

  logic signed [31:0] bass_raw;
  logic signed [31:0] rest_raw;
  assign bass_raw = ctrl_q[C_FIVE] ? 32'(b1) + 32'(b2) : 32'(b1);
  assign rest_raw = ctrl_q[C_FIVE] ? 32'(rs) : 32'(b2) + 32'(rs);

  acl_db_t     bdb;
  logic [7:0]  kn;
  logic [15:0] knw;
  logic [SW-1:0] bthr;
  logic [SW-1:0] ks;
  assign bdb = sp ? speech_q : bass_q;
  assign bthr = SW'(scale(32'(FULL), db2lin(bdb)));
  assign knw = 16'(shape_q) * 16'(KNEE_K);
  assign kn = knw[KNEE_SH+7:KNEE_SH];
  assign ks = SW'(scale(32'(bthr), db2lin(-$signed(kn))));

  logic signed [SW-1:0] bclip;
  logic signed [31:0]   sum;
  assign bclip = knee(bass_raw, ks, bthr);
  assign sum = 32'(bclip) + rest_raw;

  acl_db_t ptot;
  acl_db_t ploss;
  acl_db_t ddb;
  assign ptot = poff_q + pthr_q;
  assign ploss = (ctrl_q[C_PWR] && ptot < DB_ZERO) ? ptot : DB_ZERO;
  assign ddb = fdrv_q + ploss;

  logic signed [31:0]   fdrv;
  logic signed [SW-1:0] fclip;
  assign fdrv = scale(sum, db2lin(ddb));
  assign fclip = clip(fdrv, FULL);

  // compensator drive and clip
  // two-tap smoothing tames the fold-back of the clip edges
  logic signed [31:0]   avg;
  logic signed [SW-1:0] audio;
  assign avg = (32'(fclip) + 32'(prev_q)) >>> 1;
  assign audio = clip(scale(avg, db2lin(osdrv_q)), FULL);

  logic signed [31:0]   cval;
  logic signed [SW-1:0] csel;
  logic signed [31:0]   lp_d;
  logic signed [SW-1:0] comp;
  assign cval = scale(32'(audio), db2lin(cdrv_q));
  assign csel = ctrl_q[C_HCOS] ? knee(cval, KNEE_HC, FULL) : clip(cval, FULL);
  assign lp_d = lp_q + ((32'(csel) - lp_q) >>> LP_SH);
  assign comp = ctrl_q[C_CEN] ? clip(lp_d, FULL) : audio;

  // bus decode
  logic          ap;
  logic [AW-1:0] ra;
  logic [31:0]   rd_mux;
  assign ap = hsel & hready & htrans[1] & (hsize == W_SIZE);
  assign ra = haddr[AW-1:0];
  assign rd_mux =
    (ra == A_CTRL) ? 32'(ctrl_q) :
    (ra == A_BASS) ? {8'h00, shape_q, speech_q, bass_q} :
    (ra == A_DRV)  ? {8'h00, cdrv_q, osdrv_q, fdrv_q} :
    (ra == A_PWR)  ? {16'h0000, pthr_q, poff_q} :
    (ra == A_STAT) ? {scnt_q, 13'h0000, flags_q} : 32'h00000000;

  // write lanes
  acl_db_t w0;
  acl_db_t w1;
  acl_db_t w2;
  assign w0 = hwdata[F0+7:F0];
  assign w1 = hwdata[F1+7:F1];
  assign w2 = hwdata[F2+7:F2];

  // address phase capture; read data is ready for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= '0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      wr_q <= ap & hwrite;
      wa_q <= ra;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap && !hwrite && haddr[31:AW] == '0) begin
        hrdata <= rd_mux;
      end
    end
  end

  // data phase writes, every dB and shape field saturated to its span; control bits taken as written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RST;
      bass_q <= BASS_RST;
      speech_q <= DB_ZERO;
      shape_q <= SHAPE_RST;
      fdrv_q <= DB_ZERO;
      osdrv_q <= DB_ZERO;
      cdrv_q <= DB_ZERO;
      poff_q <= DB_ZERO;
      pthr_q <= DB_ZERO;
    end else if (ce && wr_q) begin
      case (wa_q)
        A_CTRL: begin
          ctrl_q <= hwdata[3:0];
        end
        A_BASS: begin
          bass_q <= clampdb(w0, BASS_MIN, DB_ZERO);
          speech_q <= clampdb(w1, BASS_MIN, DB_ZERO);
          shape_q <= clampdb(w2, DB_ZERO, SHAPE_MAX);
        end
        A_DRV: begin
          fdrv_q <= clampdb(w0, FD_MIN, FD_MAX);
          osdrv_q <= clampdb(w1, OS_MIN, OS_MAX);
          cdrv_q <= clampdb(w2, DB_ZERO, CD_MAX);
        end
        A_PWR: begin
          poff_q <= clampdb(w0, PO_MIN, DB_ZERO);
          pthr_q <= clampdb(w1, PT_MIN, PT_MAX);
        end
        default: begin
        end
      endcase
    end
  end

  // rate counter runs free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= '0;
    end else if (ce) begin
      tick_q <= tick ? '0 : tick_q + 1'b1;
    end
  end

  // output stage and filter state advance on a pop only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_valid <= 1'b0;
      audio_out <= '0;
      comp_out <= '0;
      prev_q <= '0;
      lp_q <= '0;
      flags_q <= '0;
      scnt_q <= '0;
    end else if (ce) begin
      if (f_valid && f_ready) begin
        out_valid <= 1'b1;
        audio_out <= audio;
        comp_out <= comp;
        prev_q <= fclip;
        lp_q <= ctrl_q[C_CEN] ? lp_d : 32'(audio);
        flags_q <= {over(cval, FULL) & ctrl_q[C_CEN],
                    over(fdrv, FULL), over(bass_raw, ks)};
        scnt_q <= scnt_q + 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ---- verif/acl_chain_asserts.sv ----
// port checker for the clip chain, bound onto acl_chain
// assumes one hclk domain, hresetn active low
`timescale 1ns/1ps
`default_nettype none
module acl_chain_asserts
  import acl_pkg::*;
(
  input wire logic          hclk,
  input wire logic          hresetn,
  input wire logic          ce,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic          in_valid,
  input wire logic          in_ready,
  input wire logic [SW-1:0] audio_out,
  input wire logic [SW-1:0] comp_out,
  input wire logic          out_valid,
  input wire logic          out_ready
);
  localparam int GAP_MIN = TICK_CYC - 1;
  localparam logic signed [SW-1:0] FS = FULL;
  logic [9:0] gap_q;
  logic       ov_q;
  wire logic signed [SW-1:0] a_s = audio_out;
  wire logic signed [SW-1:0] c_s = comp_out;
  // cycles since out_valid rose; saturates so reset looks long ago
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q <= 10'h3FF;
      ov_q  <= 1'b0;
    end else begin
      ov_q  <= out_valid;
      gap_q <= (out_valid && !ov_q) ? 10'h000 : gap_q + {9'h000, gap_q != 10'h3FF};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_pop;
    out_valid && !ov_q;
  endsequence
  sequence s_held;
    out_valid && !out_ready;
  endsequence
  a_rate_gap: assert property (s_pop |-> int'(gap_q) >= GAP_MIN)
    else $error("outputs closer than one sample tick");
  a_clip_audio: assert property (out_valid |-> a_s <= FS && a_s >= -FS)
    else $error("audio_out beyond clip level");
  a_clip_comp: assert property (out_valid |-> c_s <= FS && c_s >= -FS)
    else $error("comp_out beyond clip level");
  a_hold_out: assert property (s_held |=> out_valid && $stable(audio_out) && $stable(comp_out))
    else $error("output changed while refused");
  a_take_clears: assert property (ce && out_valid && out_ready && gap_q < 10'h190 |=> !out_valid)
    else $error("out_valid stayed after accept");
  a_fill_cause: assert property ($fell(in_ready) |-> $past(in_valid))
    else $error("in_ready fell without a take");
  a_okay_only: assert property (!hresp)
    else $error("hresp not okay");
  a_zero_wait: assert property (hreadyout)
    else $error("hreadyout low");
endmodule
bind acl_chain acl_chain_asserts u_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hreadyout(hreadyout), .hresp(hresp),
  .in_valid(in_valid), .in_ready(in_ready), .audio_out(audio_out), .comp_out(comp_out),
  .out_valid(out_valid), .out_ready(out_ready)
);
`default_nettype wire

// ---- verif/acl_far.sv ----
// far side: sample source ahead of the chain and sink behind it
// assumes the word handshake on hclk, taken on valid and ready
`timescale 1ns/1ps
`default_nettype none
module acl_far
  import acl_pkg::*;
(
  input  wire logic     hclk,
  input  wire logic     in_ready,
  output logic [SW-1:0] band1_in,
  output logic [SW-1:0] band2_in,
  output logic [SW-1:0] rest_in,
  output logic          speech_in,
  output logic          in_valid,
  output logic          out_ready
);
  logic       stall;
  logic [2:0] cyc_q;
  initial begin
    stall = 1'b0;
    cyc_q = 3'h0;
    in_valid = 1'b0;
    out_ready = 1'b0;
    {band1_in, band2_in, rest_in, speech_in} = '0;
  end
  // sink refuses one cycle in eight, so outputs must wait now and then
  always @(posedge hclk) begin
    cyc_q     <= cyc_q + 3'h1;
    out_ready <= !stall && cyc_q != 3'h0;
  end
  // word held until an edge with in_ready high; lines then carry junk
  task automatic send(input logic [SW-1:0] b1, input logic [SW-1:0] b2,
                      input logic [SW-1:0] r, input logic sp, output bit ok);
    ok = 1'b0;
    @(posedge hclk);
    band1_in  <= b1;
    band2_in  <= b2;
    rest_in   <= r;
    speech_in <= sp;
    in_valid  <= 1'b1;
    for (int n = 0; n < 2000 && !ok; n++) begin
      @(negedge hclk);
      ok = (in_ready === 1'b1);
      @(posedge hclk);
    end
    in_valid  <= 1'b0;
    band1_in  <= ~b1;
    band2_in  <= ~b2;
    rest_in   <= ~r;
    speech_in <= ~sp;
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_audio_clipper_limiter_chain.sv ----
// bench: register bus, sample stream and a model of the clip chain
// assumes acl_far on the stream side and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module tb_audio_clipper_limiter_chain;
  import acl_pkg::*;
  localparam int N = 10;
  // per test: control, bass, drive, power words; model gains in 1/1024
  localparam int CC [N] = '{1, 0, 1, 5, 13, 3, 3, 3, 1, 1};
  localparam int CB [N] = '{32'hF400, 32'hF4F4, 32'hF4F4, 0, 0, 0, 0, 0, 0, 32'hFA};
  localparam int CD [N] = '{0, 0, 32'h0A, 32'h60000, 32'h60000, 0, 0, 0, 0, 32'hFA};
  localparam int CP [N] = '{0, 0, 0, 0, 0, 32'hEE, 32'hCEE, 32'hCFA, 32'hEE, 0};
  localparam int BQ [N] = '{1024, 512, 512, 1024, 1024, 1024, 1024, 1024, 1024, 724};
  localparam int SQ [N] = '{512, 512, 512, 1024, 1024, 1024, 1024, 1024, 1024, 1024};
  localparam int GQ [N] = '{1024, 1024, 1825, 1024, 1024, 362, 724, 1024, 1024, 724};
  localparam int CQ [N] = '{1024, 1024, 1024, 1448, 1448, 1024, 1024, 1024, 1024, 1024};
  localparam logic [7:0] RA [6] = '{A_CTRL, A_BASS, A_BASS, A_DRV, A_PWR, 8'h20};
  localparam logic [31:0] RW [6] = '{0, 0, 32'h7F8080, 32'h7F7F7F, 32'h7F80, 32'h1};
  localparam logic [31:0] RV [6] = '{32'hD, 32'h4C00FA, 32'h64F4F4, 32'h6040A, 32'hCEE, 0};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire logic   hready, hresp, in_ready, in_valid, out_valid, out_ready, speech_in;
  wire logic [31:0]   hrdata;
  wire logic [SW-1:0] band1_in, band2_in, rest_in, audio_out, comp_out;
  int     bad_count = 0;
  int     total_checks = 0;
  int     seed = 67;
  int     bq, sq, g, cg;
  bit     five, cen, hc;
  longint pf = 0;
  longint lp = 0;
  longint expq [$];
  longint cmpq [$];

  acl_chain u_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .band1_in(band1_in), .band2_in(band2_in),
    .rest_in(rest_in), .speech_in(speech_in), .in_valid(in_valid), .in_ready(in_ready),
    .audio_out(audio_out), .comp_out(comp_out), .out_valid(out_valid), .out_ready(out_ready)
  );
  acl_far u_far (
    .hclk(hclk), .in_ready(in_ready), .band1_in(band1_in), .band2_in(band2_in),
    .rest_in(rest_in), .speech_in(speech_in), .in_valid(in_valid), .out_ready(out_ready)
  );

  always #4 hclk = ~hclk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(string what, longint exp, logic signed [31:0] got, longint tol);
    total_checks++;
    if ((^got) === 1'bx || longint'(got) > exp + tol || longint'(got) < exp - tol) begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic hang(string what);
    chk(what, 0, 1, 0);
    print_verdict();
  endtask

  function automatic longint lim(longint v, longint t);
    return v > t ? t : (v < -t ? -t : v);
  endfunction

  // each accepted output is held against the oldest expected sample
  always @(posedge hclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (expq.size() == 0)
        chk("spare output", 0, 1, 0);
      else begin
        chk("audio_out", expq.pop_front(), {{8{audio_out[SW-1]}}, audio_out}, 16384);
        chk("comp_out", cmpq.pop_front(), {{8{comp_out[SW-1]}}, comp_out}, 16384);
      end
    end
  end

  // waits at negedge so the sampling edge is never raced
  task automatic rdy();
    for (int n = 0; n < 64; n++) begin
      @(negedge hclk);
      if (hready === 1'b1) begin
        @(posedge hclk);
        return;
      end
    end
    hang("hready");
  endtask

  task automatic bus(bit w, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsize  <= W_SIZE;
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask

  // model: bass clip on the band sum or bass band, then gain and final clip;
  // the compensator averages two clipped samples, the composite path adds
  // drive, hard or soft limit and a one-pole smoother before its re-clip
  task automatic put(int b1, int b2, int r, bit sp);
    longint bs;
    longint fc;
    longint a;
    longint cs;
    longint m;
    longint kh;
    longint fs;
    bit     ok;
    kh = KNEE_HC;
    fs = FULL;
    bs = lim(five ? b1 + b2 : b1, fs * (sp ? sq : bq) / 1024);
    fc = lim((bs + (five ? r : b2 + r)) * g / 1024, fs);
    a = lim((fc + pf) >>> 1, fs);
    pf = fc;
    expq.push_back(a);
    cs = a * cg / 1024;
    m = cs < 0 ? -cs : cs;
    if (hc && m > kh)
      m = kh + ((m - kh) >>> 1);
    cs = lim(cs < 0 ? -m : m, fs);
    lp = cen ? lp + ((cs - lp) >>> LP_SH) : a;
    cmpq.push_back(lim(lp, fs));
    u_far.send(b1[SW-1:0], b2[SW-1:0], r[SW-1:0], sp, ok);
    if (!ok)
      hang("send");
  endtask

  task automatic drain();
    for (int n = 0; n < 30000 && expq.size() > 0; n++)
      @(posedge hclk);
    if (expq.size() > 0)
      hang("drain");
  endtask

  initial begin
    logic [31:0] rd;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (i > 1)
        bus(1'b1, RA[i], RW[i], rd);
      bus(1'b0, RA[i], 32'h0, rd);
      chk("register", RV[i], rd, 0);
    end
    $display("register test done");
    for (int i = 0; i < N; i++) begin
      bus(1'b1, A_CTRL, CC[i], rd);
      bus(1'b1, A_BASS, CB[i], rd);
      bus(1'b1, A_DRV, CD[i], rd);
      bus(1'b1, A_PWR, CP[i], rd);
      five = CC[i][0];
      bq = BQ[i];
      sq = SQ[i];
      g = GQ[i];
      cen = CC[i][2];
      hc = CC[i][3];
      cg = CQ[i];
      put(32'h180000, 32'h180000, 0, 1'b1);
      put(32'h180000, 32'h180000, 0, 1'b0);
      put(-32'h180000, -32'h180000, 0, 1'b1);
      put(0, 0, 32'h300000, 1'b0);
      drain();
      $display("setting %0d done", i);
    end
    // sink stalled: nine samples fill the output stage and the eight-deep fifo
    u_far.stall <= 1'b1;
    for (int k = 0; k < 9; k++)
      put($random(seed) % 32'shA0000, $random(seed) % 32'shA0000, $random(seed) % 32'shA0000, 0);
    repeat (3) @(negedge hclk);
    chk("in_ready", 0, {31'h0, in_ready}, 0);
    u_far.stall <= 1'b0;
    drain();
    $display("fill test done");
    print_verdict();
  end
endmodule
`default_nettype wire
